//--- common/pli_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pli_link_if;
  logic speed_100;
  logic signal_detect;
  logic nlp_strobe;
  logic pkt_ok_10;
  logic rx_active;
  logic link_up;
  modport qual (
    input speed_100, signal_detect, nlp_strobe, pkt_ok_10, rx_active,
    output link_up
  );
  modport core (
    output speed_100, signal_detect, nlp_strobe, pkt_ok_10, rx_active,
    input link_up
  );
endinterface
`default_nettype wire

//--- common/pli_pkg.sv
package pli_pkg;
  localparam int PLI_CLK_HZ = 50_000_000;
  localparam int PLI_LINK_LOSS_MS = 100;
  localparam int PLI_LINK_LOSS_CYC = PLI_LINK_LOSS_MS * (PLI_CLK_HZ / 1000);
  localparam int PLI_BLINK_MS = 100;
  localparam int PLI_BLINK_CYC = PLI_BLINK_MS * (PLI_CLK_HZ / 1000);
  localparam int PLI_NLP_TO_LINK = 7;
  localparam logic [4:0] PLI_REG_OVERRIDE = 5'h18;
  localparam logic [4:0] PLI_REG_CONTROL = 5'h19;
  localparam logic [15:0] PLI_OVR_MASK = 16'h003f;
  localparam logic [15:0] PLI_CTL_RESET = 16'h0000;
  localparam logic [15:0] PLI_OVR_RESET = 16'h0000;
  localparam int PLI_CTL_MODE_LO = 5;
  localparam int PLI_CTL_MODE_HI = 6;
  localparam int PLI_CTL_ADDR_HI = 4;
  localparam int PLI_OVR_VAL_LSB = 0;
  localparam int PLI_OVR_EN_LSB = 3;
  localparam int PLI_LINK_INDICATOR = 0;
  localparam int PLI_LED_RATE = 1;
  localparam int PLI_LED_AC = 2;
  localparam logic [1:0] PLI_MODE_COL = 2'h0;
  localparam logic [1:0] PLI_MODE_DUP = 2'h2;
  localparam logic [5:0] PLI_PRE_LEN = 6'h20;
  localparam logic [5:0] PLI_OP_LAST = 6'h01;
  localparam logic [5:0] PLI_ADR_LAST = 6'h09;
  localparam logic [5:0] PLI_DAT_LAST = 6'h0f;
  localparam logic [1:0] PLI_OP_RD = 2'h2;
  localparam logic [1:0] PLI_OP_WR = 2'h1;

  typedef enum logic [5:0] {
    PLI_PRE = 6'h01,
    PLI_ST = 6'h02,
    PLI_OP = 6'h04,
    PLI_ADR = 6'h08,
    PLI_TA = 6'h10,
    PLI_DAT = 6'h20
  } pli_mdio_e;
endpackage

//--- hdl/pli_link_qual.sv
`timescale 1ns/1ps
`default_nettype none
module pli_link_qual
  import pli_pkg::*;
#(
  parameter int LOSS_CYCLES = PLI_LINK_LOSS_CYC
) (
  input wire logic sys_clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  pli_link_if.qual lk // Raw link status in, qualified link out
);
  localparam int LW = $clog2(LOSS_CYCLES + 1);
  localparam logic [LW-1:0] LOSS_LAST = LW'(LOSS_CYCLES - 1);
  localparam logic [2:0] NLP_LAST = 3'(PLI_NLP_TO_LINK - 1);

  typedef struct packed {
    logic link;
    logic [LW-1:0] loss_cnt;
    logic [2:0] nlp_cnt;
  } pli_qual_s;

  pli_qual_s s, n;
  logic refresh, expire, up_now;

  always_comb begin
    n = s;
    refresh = lk.speed_100 ? lk.signal_detect
            : (lk.nlp_strobe | lk.pkt_ok_10 | lk.rx_active);
    expire = !refresh && (s.loss_cnt == LOSS_LAST);
    // Fast link on signal detect; 10 Mb/s on seventh pulse or a packet
    up_now = lk.speed_100 ? lk.signal_detect
           : (lk.pkt_ok_10 | (lk.nlp_strobe && s.nlp_cnt == NLP_LAST));
    if (refresh) begin
      n.loss_cnt = '0;
    end else if (!expire) begin
      n.loss_cnt = s.loss_cnt + LW'(1);
    end
    if (expire) begin
      n.nlp_cnt = 3'h0;
    end else if (lk.nlp_strobe && s.nlp_cnt != NLP_LAST) begin
      n.nlp_cnt = s.nlp_cnt + 3'h1;
    end
    if (up_now) begin
      n.link = 1'b1;
    end else if (expire) begin
      n.link = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign lk.link_up = s.link;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_fast_link_up: assert property (lk.speed_100 && lk.signal_detect |=> lk.link_up)
    else $error("link not up on signal detect");
  a_seven_pulses: assert property (!lk.speed_100 && lk.nlp_strobe && s.nlp_cnt == NLP_LAST |=> lk.link_up)
    else $error("link not up after seven pulses");
  a_loss_drop: assert property ($fell(lk.link_up) |-> $past(s.loss_cnt) == LOSS_LAST)
    else $error("link dropped before loss timer expired");
endmodule
`default_nettype wire

//--- hdl/pli_top.sv
`timescale 1ns/1ps
`default_nettype none
module pli_top
  import pli_pkg::*;
#(
  parameter int BLINK_CYCLES = PLI_BLINK_CYC,
  parameter int LOSS_CYCLES = PLI_LINK_LOSS_CYC
) (
  input wire logic sys_clk, // Core clock, 50 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic mdc, // Management clock, sampled on sys_clk
  input wire logic mdio_in, // Management data, pin level
  output logic mdio_out, // Management data drive value
  output logic mdio_oe, // Management data drive enable
  input wire logic [4:0] phy_addr_strap, // Address strap level
  input wire logic indicator_mode_select, // Strap for mode field bit 0
  input wire logic signal_detect, // 100 Mb/s receive signal present
  input wire logic speed_100, // High when running at 100 Mb/s
  input wire logic full_duplex, // High when full duplex
  input wire logic tx_active, // Transmit activity
  input wire logic rx_active, // Receive activity
  input wire logic mii_col, // MII collision, heartbeat included
  input wire logic nlp_strobe, // One pulse per normal link pulse
  input wire logic pkt_ok_10, // One pulse per valid 10 Mb/s packet
  input wire logic link_indicator_in, // Link pin level, strap
  output logic link_indicator_out, // Link pin drive value
  output logic link_indicator_oe, // Link pin drive enable
  input wire logic rate_indicator_in, // Rate pin level, strap
  output logic rate_indicator_out, // Rate pin drive value
  output logic rate_indicator_oe, // Rate pin drive enable
  input wire logic activity_collision_indicator_in, // Act pin, strap
  output logic activity_collision_indicator_out, // Act pin drive value
  output logic activity_collision_indicator_oe // Act pin drive enable
);
  localparam int BW = $clog2(BLINK_CYCLES + 1);
  localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYCLES - 1);

  typedef struct packed {
    pli_mdio_e st;
    logic [5:0] cnt;
    logic [1:0] op;
    logic [9:0] adr;
    logic [15:0] sh;
    logic rd;
    logic mdc_q;
    logic mdio_out;
    logic mdio_oe;
    logic [15:0] ovr;
    logic [15:0] ctl;
    logic done;
    logic [2:0] pol;
    logic [2:0] led_lvl;
    logic [2:0] led_oe;
    logic [BW-1:0] blink_cnt;
    logic blink_ph;
  } pli_core_s;

  pli_core_s s, n;
  pli_link_if lk ();

  logic [2:0] led_in;
  logic [2:0] func;
  logic [2:0] lit;
  logic [2:0] ovr_en;
  logic [1:0] mode;
  logic act;
  logic col_ok;
  logic [15:0] wr_data;

  // Override reads return the stored override bits, not pin levels
  function automatic logic [15:0] read_reg(input logic [15:0] ovr,
                                           input logic [15:0] ctl,
                                           input logic [4:0] ra);
    logic [15:0] d;
    d = 16'h0000;
    if (ra == PLI_REG_OVERRIDE) begin
      d = ovr & PLI_OVR_MASK;
    end else if (ra == PLI_REG_CONTROL) begin
      d = ctl;
    end
    return d;
  endfunction

  assign lk.speed_100 = speed_100;
  assign lk.signal_detect = signal_detect;
  assign lk.nlp_strobe = nlp_strobe;
  assign lk.pkt_ok_10 = pkt_ok_10;
  assign lk.rx_active = rx_active;

  pli_link_qual #(
    .LOSS_CYCLES(LOSS_CYCLES)
  ) u_qual (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lk(lk)
  );

  assign led_in = {activity_collision_indicator_in, rate_indicator_in,
                   link_indicator_in};

  always_comb begin
    n = s;
    wr_data = {s.sh[14:0], mdio_in};
    n.mdc_q = mdc;
    // Serial management frame, one bit per MDC rising edge
    if (mdc && !s.mdc_q) begin
      unique case (s.st)
        PLI_PRE: begin
          if (mdio_in) begin
            if (s.cnt != PLI_PRE_LEN) begin
              n.cnt = s.cnt + 6'h01;
            end
          end else if (s.cnt == PLI_PRE_LEN) begin
            n.st = PLI_ST;
            n.cnt = 6'h00;
          end else begin
            n.cnt = 6'h00;
          end
        end
        PLI_ST: begin
          n.st = mdio_in ? PLI_OP : PLI_PRE;
          n.cnt = 6'h00;
        end
        PLI_OP: begin
          n.op = {s.op[0], mdio_in};
          if (s.cnt == PLI_OP_LAST) begin
            n.st = PLI_ADR;
            n.cnt = 6'h00;
          end else begin
            n.cnt = s.cnt + 6'h01;
          end
        end
        PLI_ADR: begin
          n.adr = {s.adr[8:0], mdio_in};
          if (s.cnt == PLI_ADR_LAST) begin
            // Five address bits select the register; only two of the thirty-two hold data
            n.st = (s.op == PLI_OP_RD || s.op == PLI_OP_WR) ? PLI_TA
                 : PLI_PRE;
            n.rd = (s.op == PLI_OP_RD) &&
                   (n.adr[9:5] == s.ctl[PLI_CTL_ADDR_HI:0]);
            n.sh = read_reg(s.ovr, s.ctl, n.adr[4:0]);
            n.cnt = 6'h00;
          end else begin
            n.cnt = s.cnt + 6'h01;
          end
        end
        PLI_TA: begin
          if (s.cnt == 6'h00) begin
            n.mdio_oe = s.rd;
            n.mdio_out = 1'b0;
            n.cnt = 6'h01;
          end else begin
            n.st = PLI_DAT;
            n.cnt = 6'h00;
            n.mdio_out = s.sh[15];
            n.sh = {s.sh[14:0], 1'b0};
          end
        end
        PLI_DAT: begin
          if (s.rd) begin
            if (s.cnt == PLI_DAT_LAST) begin
              n.mdio_oe = 1'b0;
              n.mdio_out = 1'b0;
              n.rd = 1'b0;
              n.st = PLI_PRE;
              n.cnt = 6'h00;
            end else begin
              n.mdio_out = s.sh[15];
              n.sh = {s.sh[14:0], 1'b0};
              n.cnt = s.cnt + 6'h01;
            end
          end else begin
            n.sh = wr_data;
            if (s.cnt == PLI_DAT_LAST) begin
              n.st = PLI_PRE;
              n.cnt = 6'h00;
              if (s.op == PLI_OP_WR &&
                  s.adr[9:5] == s.ctl[PLI_CTL_ADDR_HI:0]) begin
                if (s.adr[4:0] == PLI_REG_OVERRIDE) begin
                  n.ovr = wr_data & PLI_OVR_MASK;
                end else if (s.adr[4:0] == PLI_REG_CONTROL) begin
                  n.ctl = wr_data;
                end
              end
            end else begin
              n.cnt = s.cnt + 6'h01;
            end
          end
        end
        default: begin
          n.st = PLI_PRE;
          n.cnt = 6'h00;
          n.rd = 1'b0;
          n.mdio_oe = 1'b0;
        end
      endcase
    end

    // Free-running blink phase
    if (s.blink_cnt == BLINK_LAST) begin
      n.blink_cnt = '0;
      n.blink_ph = !s.blink_ph;
    end else begin
      n.blink_cnt = s.blink_cnt + BW'(1);
    end

    mode = s.ctl[PLI_CTL_MODE_HI:PLI_CTL_MODE_LO];
    act = tx_active | rx_active;
    col_ok = mii_col & !full_duplex;
    func[PLI_LED_RATE] = speed_100;
    if (mode[0]) begin
      func[PLI_LINK_INDICATOR] = lk.link_up;
      func[PLI_LED_AC] = act;
    end else begin
      func[PLI_LINK_INDICATOR] = lk.link_up & !(act & s.blink_ph);
      func[PLI_LED_AC] = (mode == PLI_MODE_DUP) ? full_duplex
                       : col_ok;
    end
    ovr_en = s.ovr[PLI_OVR_EN_LSB +: 3];
    lit = (ovr_en & s.ovr[PLI_OVR_VAL_LSB +: 3]) | (~ovr_en & func);

    // Straps are read while the pins are released, then drive starts
    if (!s.done) begin
      n.done = 1'b1;
      n.pol = led_in;
      n.ctl[PLI_CTL_ADDR_HI:0] = phy_addr_strap;
      n.ctl[PLI_CTL_MODE_LO] = indicator_mode_select;
      n.led_oe = 3'h0;
      n.led_lvl = 3'h0;
    end else begin
      n.led_oe = 3'h7;
      n.led_lvl = lit ^ s.pol;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= PLI_PRE;
      s.ctl <= PLI_CTL_RESET;
      s.ovr <= PLI_OVR_RESET;
    end else begin
      s <= n;
    end
  end

  assign mdio_out = s.mdio_out;
  assign mdio_oe = s.mdio_oe;
  assign link_indicator_out = s.led_lvl[PLI_LINK_INDICATOR];
  assign rate_indicator_out = s.led_lvl[PLI_LED_RATE];
  assign activity_collision_indicator_out = s.led_lvl[PLI_LED_AC];
  assign link_indicator_oe = s.led_oe[PLI_LINK_INDICATOR];
  assign rate_indicator_oe = s.led_oe[PLI_LED_RATE];
  assign activity_collision_indicator_oe = s.led_oe[PLI_LED_AC];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_rate_follow: assert property (s.done && !ovr_en[PLI_LED_RATE] |=> rate_indicator_out == ($past(speed_100) ^ s.pol[PLI_LED_RATE]))
    else $error("rate indicator does not follow speed");
  a_act_mode1: assert property (s.done && !ovr_en[PLI_LED_AC] && mode[0] |=> activity_collision_indicator_out == ($past(act) ^ s.pol[PLI_LED_AC]))
    else $error("activity indicator wrong in mode 1");
  a_link_mode1: assert property (s.done && !ovr_en[PLI_LINK_INDICATOR] && mode[0] |=> link_indicator_out == ($past(lk.link_up) ^ s.pol[PLI_LINK_INDICATOR]))
    else $error("link indicator wrong in mode 1");
  a_col_mode2: assert property (s.done && !ovr_en[PLI_LED_AC] && mode == PLI_MODE_COL |=> activity_collision_indicator_out == ($past(mii_col && !full_duplex) ^ s.pol[PLI_LED_AC]))
    else $error("collision indicator wrong in mode 2");
  a_dup_mode3: assert property (s.done && !ovr_en[PLI_LED_AC] && mode == PLI_MODE_DUP |=> activity_collision_indicator_out == ($past(full_duplex) ^ s.pol[PLI_LED_AC]))
    else $error("duplex indicator wrong in mode 3");
  a_link_blink: assert property (s.done && !ovr_en[PLI_LINK_INDICATOR] && !mode[0] && lk.link_up && act && s.blink_ph |=> link_indicator_out == s.pol[PLI_LINK_INDICATOR])
    else $error("link indicator not dark in blink phase");
  a_override_link: assert property (s.done && ovr_en[PLI_LINK_INDICATOR] |=> link_indicator_out == ($past(s.ovr[PLI_OVR_VAL_LSB]) ^ s.pol[PLI_LINK_INDICATOR]))
    else $error("link override not applied");
  a_strap_pol: assert property ($rose(s.done) |-> s.pol == $past(led_in) && !link_indicator_oe)
    else $error("polarity not taken from straps");
endmodule
`default_nettype wire

//--- tb/phy_led_indicator_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module phy_led_indicator_tb_top
  import pli_pkg::*;
;
  localparam int LOSS = 20;
  localparam logic [2:0] STRAP = 3'h2;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mdc = 1'b0;
  logic m_drv = 1'b1;
  logic m_oe = 1'b1;
  logic msel = 1'b1;
  logic mdio_in, mdio_out, mdio_oe;
  logic sd = 1'b0, spd = 1'b0, fd = 1'b0, tx = 1'b0, rx = 1'b0;
  logic col = 1'b0, nlp = 1'b0, pkt = 1'b0, feed = 1'b0;
  logic [2:0] drv, oe, pin, lit;
  logic [15:0] rd = 16'h0;
  logic [15:0] n;
  logic [9:0] r;
  int err_count = 0;
  int total_checks = 0;
  // mode, speed, duplex, tx, rx, col, expected act/rate/link
  logic [9:0] rows [11] = '{10'h1a7, 10'h3d7, 10'h18b, 10'h08f,
    10'h083, 10'h0cb, 10'h2c7, 10'h283, 10'h00d, 10'h201, 10'h115};

  // Pull-up on the shared management line
  assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_drv : 1'b1);

  pli_top #(.BLINK_CYCLES(4), .LOSS_CYCLES(LOSS)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr_strap(5'h01),
    .indicator_mode_select(msel), .signal_detect(sd),
    .speed_100(spd), .full_duplex(fd), .tx_active(tx),
    .rx_active(rx), .mii_col(col), .nlp_strobe(nlp), .pkt_ok_10(pkt),
    .link_indicator_in(pin[0]), .link_indicator_out(drv[0]),
    .link_indicator_oe(oe[0]), .rate_indicator_in(pin[1]),
    .rate_indicator_out(drv[1]), .rate_indicator_oe(oe[1]),
    .activity_collision_indicator_in(pin[2]),
    .activity_collision_indicator_out(drv[2]),
    .activity_collision_indicator_oe(oe[2]));

  pli_led_model #(.STRAP(STRAP)) leds (
    .drv(drv), .oe(oe), .pin(pin), .lit(lit));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // Link pulse source: one pulse every other cycle while feed is set
  always @(negedge sys_clk) nlp <= feed && !nlp;

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One management frame; mdc phases last two cycles each
  task automatic mdio(input logic [1:0] op, input logic [4:0] pa,
                      input logic [4:0] ra, input logic [15:0] wd);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
    for (int i = 0; i < 64; i++) begin
      @(negedge sys_clk);
      mdc = 1'b0;
      m_oe = !(op == PLI_OP_RD && i >= 46);
      m_drv = f[63 - i];
      cyc(1);
      if (i >= 48) rd = {rd[14:0], mdio_in};
      cyc(1);
      mdc = 1'b1;
      cyc(1);
    end
    cyc(1);
    mdc = 1'b0;
    m_oe = 1'b1;
    m_drv = 1'b1;
    cyc(4);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    mdio(PLI_OP_WR, 5'h01, ra, wd);
  endtask

  task automatic rdc(input logic [4:0] pa, input logic [4:0] ra,
                     input logic [15:0] exp);
    mdio(PLI_OP_RD, pa, ra, 16'h0);
    chk(rd, exp);
  endtask

  initial begin
    cyc(40000);
    err_count++;
    give_verdict();
  end

  initial begin
    cyc(4);
    chk({13'h0, oe}, 16'h0);
    chk({13'h0, pin}, {13'h0, STRAP});
    rst_n = 1'b1;
    cyc(3);
    chk({13'h0, lit}, 16'h0);
    rdc(5'h01, PLI_REG_CONTROL, 16'h0021);
    for (int i = 0; i < 11; i++) begin
      r = rows[i];
      spd = r[7];
      sd = r[7];
      feed <= !r[7];
      fd = r[6];
      wr(PLI_REG_CONTROL, {9'h0, r[9:8], 5'h01});
      tx = r[5];
      rx = r[4];
      col = r[3];
      cyc(3);
      chk({13'h0, lit}, {13'h0, r[2:0]});
    end
    $display("test mode table done");
    {spd, sd, fd, tx, rx, col} = 6'h0;
    feed <= 1'b0;
    cyc(LOSS + 10);
    chk({15'h0, lit[0]}, 16'h0);
    feed <= 1'b1;
    cyc(12);
    feed <= 1'b0;
    cyc(2);
    chk({15'h0, lit[0]}, 16'h0);
    feed <= 1'b1;
    cyc(2);
    feed <= 1'b0;
    cyc(3);
    chk({15'h0, lit[0]}, 16'h1);
    cyc(10);
    chk({15'h0, lit[0]}, 16'h1);
    cyc(LOSS);
    chk({15'h0, lit[0]}, 16'h0);
    pkt = 1'b1;
    cyc(1);
    pkt = 1'b0;
    cyc(3);
    chk({15'h0, lit[0]}, 16'h1);
    cyc(LOSS + 10);
    spd = 1'b1;
    sd = 1'b1;
    cyc(3);
    chk({13'h0, lit}, 16'h3);
    sd = 1'b0;
    cyc(10);
    chk({15'h0, lit[0]}, 16'h1);
    cyc(LOSS);
    chk({15'h0, lit[0]}, 16'h0);
    $display("test link qualify done");
    sd = 1'b1;
    wr(PLI_REG_CONTROL, 16'h0001);
    tx = 1'b1;
    cyc(3);
    n = 16'h0;
    for (int i = 0; i < 16; i++) begin
      cyc(1);
      n = n + {15'h0, !lit[0]};
    end
    chk(n, 16'h0008);
    tx = 1'b0;
    cyc(3);
    chk({15'h0, lit[0]}, 16'h1);
    $display("test blink done");
    wr(PLI_REG_OVERRIDE, 16'h0007);
    cyc(3);
    chk({13'h0, lit}, 16'h3);
    rdc(5'h01, PLI_REG_OVERRIDE, 16'h0007);
    wr(PLI_REG_OVERRIDE, 16'h003f);
    chk({13'h0, lit}, 16'h7);
    wr(PLI_REG_OVERRIDE, 16'h0038);
    chk({13'h0, lit}, 16'h0);
    wr(PLI_REG_OVERRIDE, 16'h0028);
    chk({13'h0, lit}, 16'h2);
    $display("test override done");
    rdc(5'h01, 5'h05, 16'h0000);
    rdc(5'h02, PLI_REG_CONTROL, 16'hffff);
    mdio(PLI_OP_WR, 5'h02, PLI_REG_CONTROL, 16'h0041);
    rdc(5'h01, PLI_REG_CONTROL, 16'h0001);
    $display("test refusal done");
    rst_n = 1'b0;
    // Mode strap low this time, so bit 5 must come back clear
    msel = 1'b0;
    cyc(1);
    chk({13'h0, oe}, 16'h0);
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    rdc(5'h01, PLI_REG_CONTROL, 16'h0001);
    rdc(5'h01, PLI_REG_OVERRIDE, PLI_OVR_RESET);
    $display("test mid reset done");
    give_verdict();
  end
endmodule
`default_nettype wire

//--- tb/pli_led_model.sv
`timescale 1ns/1ps
`default_nettype none
module pli_led_model #(
  parameter logic [2:0] STRAP = 3'h2
) (
  input wire logic [2:0] drv, // Drive values: link, rate, act
  input wire logic [2:0] oe, // Drive enables
  output logic [2:0] pin, // Resolved pin levels
  output logic [2:0] lit // Lamp lit
);
  // Strap resistor sets the level whenever the pin is not driven
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin[i] = oe[i] ? drv[i] : STRAP[i];
    end
  end
  // High strap means the lamp sits between supply and pin
  assign lit = pin ^ STRAP;
endmodule
`default_nettype wire
